// file: hw/pls_pkg.sv
package pls_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses)
   localparam logic [7:0]  PLS_CTRL_OFS        = 8'h00;
   localparam logic [7:0]  PLS_RFN_OFS         = 8'h04;
   localparam logic [7:0]  PLS_STAT_OFS        = 8'h08;

   // Control register fields
   localparam int          PLS_CTRL_RF_SLEEP   = 0;
   localparam int          PLS_CTRL_IF_SLEEP   = 1;
   localparam int          PLS_CTRL_RF_FLOAT   = 2;
   localparam int          PLS_CTRL_IF_FLOAT   = 3;
   localparam int          PLS_CTRL_WAKE_LSB   = 4;
   localparam int          PLS_CTRL_SEL_LSB    = 8;
   localparam logic [31:0] PLS_CTRL_RST        = 32'h0000_0000;

   // Feedback counter register
   localparam int          PLS_RFN_W           = 18;
   localparam logic [17:0] PLS_RFN_RST         = 18'h0_0000;

   // Status register fields
   localparam int          PLS_STAT_RF_LOCK    = 0;
   localparam int          PLS_STAT_IF_LOCK    = 1;
   localparam int          PLS_STAT_EN         = 2;
   localparam int          PLS_STAT_RF_ST_LSB  = 4;
   localparam int          PLS_STAT_IF_ST_LSB  = 6;

   // Test pin selections
   localparam logic [3:0]  PLS_SEL_LOW         = 4'h0;
   localparam logic [3:0]  PLS_SEL_RF_LOCK     = 4'h1;
   localparam logic [3:0]  PLS_SEL_IF_LOCK     = 4'h2;
   localparam logic [3:0]  PLS_SEL_BOTH_LOCK   = 4'h3;

   // Lock detection windows, phase error measured in picoseconds
   localparam int          PLS_LOCK_CYCLES     = 5;
   localparam int          PLS_PS_PER_NS       = 1000;
   localparam int          PLS_RF_ENTER_NS     = 10;
   localparam int          PLS_RF_EXIT_NS      = 20;
   localparam int          PLS_IF_ENTER_NS     = 15;
   localparam int          PLS_IF_EXIT_NS      = 30;
   localparam int          PLS_ERR_W           = 16;
   localparam logic [15:0] PLS_RF_ENTER_PS     = 16'(PLS_RF_ENTER_NS * PLS_PS_PER_NS);
   localparam logic [15:0] PLS_RF_EXIT_PS      = 16'(PLS_RF_EXIT_NS * PLS_PS_PER_NS);
   localparam logic [15:0] PLS_IF_ENTER_PS     = 16'(PLS_IF_ENTER_NS * PLS_PS_PER_NS);
   localparam logic [15:0] PLS_IF_EXIT_PS      = 16'(PLS_IF_EXIT_NS * PLS_PS_PER_NS);

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      PLS_PWR_ACTIVE,
      PLS_PWR_FLOAT,
      PLS_PWR_SYNC_WAIT,
      PLS_PWR_DOWN
   } pls_pwr_e;

   typedef struct packed {
      logic [3:0] test_pin_select;
      logic [1:0] rf_auto_wake_field;
      logic       if_pump_float;
      logic       rf_pump_float;
      logic       if_section_sleep;
      logic       rf_section_sleep;
   } pls_ctrl_s;

   typedef struct packed {
      logic power_on;
      logic pump_on;
      logic pump_hiz;
   } pls_pwr_out_s;

   ////////////////////////////////////////////////////////////////////////////
   // Power state of one loop from enable, sleep, float, wake and pump activity
   function automatic pls_pwr_e pls_next_pwr(input pls_pwr_e cur,
                                             input logic     en,
                                             input logic     wake,
                                             input logic     sleep,
                                             input logic     pfloat,
                                             input logic     pump_busy);
      pls_pwr_e n;
      n = cur;
      if (!en) begin
         n = PLS_PWR_DOWN;
      end else if (wake) begin
         n = PLS_PWR_ACTIVE;
      end else if (!sleep) begin
         n = pfloat ? PLS_PWR_FLOAT : PLS_PWR_ACTIVE;
      end else if (pfloat) begin
         n = PLS_PWR_DOWN;
      end else if (cur == PLS_PWR_DOWN) begin
         n = PLS_PWR_DOWN;
      end else begin
         // Glitch-free shutdown: hold power until the pump has gone quiet
         n = pump_busy ? PLS_PWR_SYNC_WAIT : PLS_PWR_DOWN;
      end
      return n;
   endfunction : pls_next_pwr

   function automatic pls_pwr_out_s pls_pwr_out(input pls_pwr_e st);
      pls_pwr_out_s o;
      o.power_on = (st != PLS_PWR_DOWN);
      o.pump_on  = (st == PLS_PWR_ACTIVE);
      o.pump_hiz = (st == PLS_PWR_FLOAT);
      return o;
   endfunction : pls_pwr_out

endpackage : pls_pkg

// file: hw/pls_lock_det.sv
`timescale 1ns/1ps
module pls_lock_det
   import pls_pkg::*;
#(
   parameter int          COUNT     = PLS_LOCK_CYCLES,
   parameter logic [15:0] WIN_ENTER = PLS_RF_ENTER_PS,
   parameter logic [15:0] WIN_EXIT  = PLS_RF_EXIT_PS
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 ce,
   // Phase comparison result, one strobe per reference cycle
   input  wire logic                 cmp_strobe,
   input  wire logic [PLS_ERR_W-1:0] phase_err,
   input  wire logic                 powered,
   // Lock indication
   output logic                      lock
);

   localparam int CW = $clog2(COUNT + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          lock;
   } pls_ld_s;

   pls_ld_s st_r;
   pls_ld_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (!powered) begin
         st_nxt.cnt  = '0;
         st_nxt.lock = 1'b0;
      end else if (cmp_strobe) begin
         if (st_r.lock) begin
            if (phase_err > WIN_EXIT) begin
               st_nxt.lock = 1'b0;
               st_nxt.cnt  = '0;
            end
         end else if (phase_err < WIN_ENTER) begin
            if (st_r.cnt == CW'(COUNT - 1)) begin
               st_nxt.lock = 1'b1;
               st_nxt.cnt  = '0;
            end else begin
               st_nxt.cnt = st_r.cnt + CW'(1);
            end
         end else begin
            st_nxt.cnt = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign lock = st_r.lock;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_in_win;
      ce && powered && cmp_strobe && !st_r.lock && (phase_err < WIN_ENTER);
   endsequence

   property p_lock_entry;
      @(posedge clk) disable iff (!rst_n)
      $rose(st_r.lock) |-> $past(st_r.cnt) == CW'(COUNT - 1);
   endproperty
   a_lock_entry: assert property (p_lock_entry) else $error("lock rose early");

   property p_lock_exit;
      @(posedge clk) disable iff (!rst_n)
      ce && powered && cmp_strobe && st_r.lock && (phase_err > WIN_EXIT) |=> !st_r.lock;
   endproperty
   a_lock_exit: assert property (p_lock_exit) else $error("lock kept past exit window");

   property p_lock_powerdown;
      @(posedge clk) disable iff (!rst_n)
      ce && !powered |=> !st_r.lock && (st_r.cnt == '0);
   endproperty
   a_lock_powerdown: assert property (p_lock_powerdown) else $error("lock while powered down");

   property p_cnt_step;
      @(posedge clk) disable iff (!rst_n)
      s_in_win and (st_r.cnt != CW'(COUNT - 1)) |=> st_r.cnt == $past(st_r.cnt) + CW'(1);
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("entry counter did not advance");

endmodule : pls_lock_det

// file: hw/pls_top.sv
//
// Functional notes
// - Enable low forces asynchronous power-down always.
// - Enable high, sleep bits clear: both sections on.
// - Sleep bit downs its own section unless woken.
// - Synchronous power-down waits for pump off first.
// - Asynchronous power-down cuts power immediately.
// - Feedback write with auto-wake activates RF loop.
// - Float bit alone keeps loop on, pump high-Z.
// - Sleep picks synchronous, or asynchronous when floated.
// - Lock after five in-window cycles under 10 ns.
// - Locked window widens to 20 ns for exit.
// - Any power-down state forces lock low.
// - IF lock enters at 15 ns, exits 30 ns.
// - Combined test output low if either unlocked.
//
`timescale 1ns/1ps
module pls_top
   import pls_pkg::*;
(
   // Clock, reset, clock enable
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 clk_en,
   // AHB-Lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   // Chip enable pin and charge pump activity (asynchronous)
   input  wire logic                 chip_enable,
   input  wire logic                 rf_pump_busy,
   input  wire logic                 if_pump_busy,
   // Phase comparison results per reference cycle
   input  wire logic                 rf_cmp_strobe,
   input  wire logic [PLS_ERR_W-1:0] rf_phase_err,
   input  wire logic                 if_cmp_strobe,
   input  wire logic [PLS_ERR_W-1:0] if_phase_err,
   // Section power controls
   output logic                      rf_power_on,
   output logic                      rf_pump_on,
   output logic                      rf_pump_hiz,
   output logic                      if_power_on,
   output logic                      if_pump_on,
   output logic                      if_pump_hiz,
   // Test / lock output pin
   output logic                      test_pin
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [1:0]           en_sync;
      logic [1:0]           rf_busy_sync;
      logic [1:0]           if_busy_sync;
      logic                 dph_valid;
      logic                 dph_write;
      logic [7:0]           dph_addr;
      logic [31:0]          hrdata;
      logic                 hreadyout;
      pls_ctrl_s            ctrl;
      logic [PLS_RFN_W-1:0] rf_fb_count;
      pls_pwr_e             rf_state;
      pls_pwr_e             if_state;
      pls_pwr_out_s         rf_out;
      pls_pwr_out_s         if_out;
      logic                 test_pin;
   } pls_state_s;

   pls_state_s st_r;
   pls_state_s st_nxt;

   logic       rf_lock;
   logic       if_lock;
   logic       en_s;
   logic       rf_busy_s;
   logic       if_busy_s;
   logic       addr_ok;
   logic       wr_ctrl;
   logic       wr_rfn;
   logic       rf_wake;
   logic [1:0] rf_st_code;
   logic [1:0] if_st_code;

   // Only the second stage of each synchroniser feeds logic
   assign en_s      = st_r.en_sync[1];
   assign rf_busy_s = st_r.rf_busy_sync[1];
   assign if_busy_s = st_r.if_busy_sync[1];

   assign addr_ok    = hsel && htrans[1] && hready;
   assign wr_ctrl    = st_r.dph_valid && st_r.dph_write && (st_r.dph_addr == PLS_CTRL_OFS);
   assign wr_rfn     = st_r.dph_valid && st_r.dph_write && (st_r.dph_addr == PLS_RFN_OFS);
   assign rf_wake    = wr_rfn && (st_r.ctrl.rf_auto_wake_field != 2'h0);
   assign rf_st_code = st_r.rf_state;
   assign if_st_code = st_r.if_state;

   ////////////////////////////////////////////////////////////////////////////
   // Register read mux, sampled in the address phase so data is ready at once
   function automatic logic [31:0] pls_read(input logic [7:0] a, input pls_state_s s,
                                            input logic rl, input logic il, input logic en,
                                            input logic [1:0] rs, input logic [1:0] is);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (a)
         PLS_CTRL_OFS: begin
            d[PLS_CTRL_RF_SLEEP]                  = s.ctrl.rf_section_sleep;
            d[PLS_CTRL_IF_SLEEP]                  = s.ctrl.if_section_sleep;
            d[PLS_CTRL_RF_FLOAT]                  = s.ctrl.rf_pump_float;
            d[PLS_CTRL_IF_FLOAT]                  = s.ctrl.if_pump_float;
            d[PLS_CTRL_WAKE_LSB +: 2]             = s.ctrl.rf_auto_wake_field;
            d[PLS_CTRL_SEL_LSB +: 4]              = s.ctrl.test_pin_select;
         end
         PLS_RFN_OFS: begin
            d[PLS_RFN_W-1:0]                      = s.rf_fb_count;
         end
         PLS_STAT_OFS: begin
            d[PLS_STAT_RF_LOCK]                   = rl;
            d[PLS_STAT_IF_LOCK]                   = il;
            d[PLS_STAT_EN]                        = en;
            d[PLS_STAT_RF_ST_LSB +: 2]            = rs;
            d[PLS_STAT_IF_ST_LSB +: 2]            = is;
         end
         default: begin
            d = 32'h0000_0000;
         end
      endcase
      return d;
   endfunction : pls_read

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;

      st_nxt.en_sync      = {st_r.en_sync[0], chip_enable};
      st_nxt.rf_busy_sync = {st_r.rf_busy_sync[0], rf_pump_busy};
      st_nxt.if_busy_sync = {st_r.if_busy_sync[0], if_pump_busy};

      // Zero wait states; unmapped addresses read zero and ignore writes
      st_nxt.hreadyout = 1'b1;
      if (hready) begin
         st_nxt.dph_valid = addr_ok;
         st_nxt.dph_write = hwrite;
         st_nxt.dph_addr  = {haddr[7:2], 2'b00};
      end

      if (wr_ctrl) begin
         st_nxt.ctrl.rf_section_sleep   = hwdata[PLS_CTRL_RF_SLEEP];
         st_nxt.ctrl.if_section_sleep   = hwdata[PLS_CTRL_IF_SLEEP];
         st_nxt.ctrl.rf_pump_float      = hwdata[PLS_CTRL_RF_FLOAT];
         st_nxt.ctrl.if_pump_float      = hwdata[PLS_CTRL_IF_FLOAT];
         st_nxt.ctrl.rf_auto_wake_field = hwdata[PLS_CTRL_WAKE_LSB +: 2];
         st_nxt.ctrl.test_pin_select    = hwdata[PLS_CTRL_SEL_LSB +: 4];
      end
      if (wr_rfn) begin
         st_nxt.rf_fb_count = hwdata[PLS_RFN_W-1:0];
      end
      // Auto-wake clears the RF sleep and float bits so the loop stays up
      if (rf_wake && en_s) begin
         st_nxt.ctrl.rf_section_sleep = 1'b0;
         st_nxt.ctrl.rf_pump_float    = 1'b0;
      end

      // Read after write: a write landing at this edge is already visible
      if (addr_ok && !hwrite) begin
         st_nxt.hrdata = pls_read({haddr[7:2], 2'b00}, st_nxt, rf_lock, if_lock, en_s,
                                  rf_st_code, if_st_code);
      end

      // Each section follows only its own sleep and float bits
      st_nxt.rf_state = pls_next_pwr(st_r.rf_state, en_s, rf_wake,
                                     st_r.ctrl.rf_section_sleep,
                                     st_r.ctrl.rf_pump_float, rf_busy_s);
      st_nxt.if_state = pls_next_pwr(st_r.if_state, en_s, 1'b0,
                                     st_r.ctrl.if_section_sleep,
                                     st_r.ctrl.if_pump_float, if_busy_s);
      st_nxt.rf_out   = pls_pwr_out(st_nxt.rf_state);
      st_nxt.if_out   = pls_pwr_out(st_nxt.if_state);

      // RF lock is not trusted above a 20 MHz comparison rate; software's call
      unique case (st_r.ctrl.test_pin_select)
         PLS_SEL_RF_LOCK:   st_nxt.test_pin = rf_lock;
         PLS_SEL_IF_LOCK:   st_nxt.test_pin = if_lock;
         PLS_SEL_BOTH_LOCK: st_nxt.test_pin = rf_lock && if_lock;
         default:           st_nxt.test_pin = 1'b0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r           <= '0;
         st_r.ctrl      <= pls_ctrl_s'(PLS_CTRL_RST[9:0]);
         st_r.rf_state  <= PLS_PWR_DOWN;
         st_r.if_state  <= PLS_PWR_DOWN;
         st_r.hreadyout <= 1'b1;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   pls_lock_det #(
      .COUNT     (PLS_LOCK_CYCLES),
      .WIN_ENTER (PLS_RF_ENTER_PS),
      .WIN_EXIT  (PLS_RF_EXIT_PS)
   ) u_rf_lock (
      .clk        (hclk),
      .rst_n      (hresetn),
      .ce         (clk_en),
      .cmp_strobe (rf_cmp_strobe),
      .phase_err  (rf_phase_err),
      .powered    (st_r.rf_out.power_on),
      .lock       (rf_lock)
   );

   pls_lock_det #(
      .COUNT     (PLS_LOCK_CYCLES),
      .WIN_ENTER (PLS_IF_ENTER_PS),
      .WIN_EXIT  (PLS_IF_EXIT_PS)
   ) u_if_lock (
      .clk        (hclk),
      .rst_n      (hresetn),
      .ce         (clk_en),
      .cmp_strobe (if_cmp_strobe),
      .phase_err  (if_phase_err),
      .powered    (st_r.if_out.power_on),
      .lock       (if_lock)
   );

   ////////////////////////////////////////////////////////////////////////////
   assign hrdata      = st_r.hrdata;
   assign hreadyout   = st_r.hreadyout;
   assign hresp       = 1'b0;
   assign rf_power_on = st_r.rf_out.power_on;
   assign rf_pump_on  = st_r.rf_out.pump_on;
   assign rf_pump_hiz = st_r.rf_out.pump_hiz;
   assign if_power_on = st_r.if_out.power_on;
   assign if_pump_on  = st_r.if_out.pump_on;
   assign if_pump_hiz = st_r.if_out.pump_hiz;
   assign test_pin    = st_r.test_pin;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_rf_steady;
      clk_en && en_s && !rf_wake;
   endsequence

   sequence s_rf_sync_sleep;
      st_r.ctrl.rf_section_sleep && !st_r.ctrl.rf_pump_float;
   endsequence

   property p_en_low;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && !en_s |=> !rf_power_on && !if_power_on;
   endproperty
   a_en_low: assert property (p_en_low) else $error("powered while enable low");

   property p_en_pump;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && !en_s |=> !rf_pump_on && !rf_pump_hiz && !if_pump_on && !if_pump_hiz;
   endproperty
   a_en_pump: assert property (p_en_pump) else $error("pump live while enable low");

   property p_both_on;
      @(posedge hclk) disable iff (!hresetn)
      s_rf_steady and (!st_r.ctrl.rf_section_sleep && !st_r.ctrl.if_section_sleep)
      |=> rf_power_on && if_power_on;
   endproperty
   a_both_on: assert property (p_both_on) else $error("section off with sleep clear");

   property p_if_only_sleep;
      @(posedge hclk) disable iff (!hresetn)
      s_rf_steady and (!st_r.ctrl.rf_section_sleep && st_r.ctrl.if_section_sleep
      && st_r.ctrl.if_pump_float) |=> rf_power_on && !if_power_on;
   endproperty
   a_if_only_sleep: assert property (p_if_only_sleep) else $error("wrong section slept");

   property p_sync_wait;
      @(posedge hclk) disable iff (!hresetn)
      s_rf_steady and s_rf_sync_sleep and (rf_busy_s
      && (st_r.rf_state != PLS_PWR_DOWN)) |=> rf_power_on && !rf_pump_on;
   endproperty
   a_sync_wait: assert property (p_sync_wait) else $error("power cut with pump busy");

   property p_sync_release;
      @(posedge hclk) disable iff (!hresetn)
      s_rf_steady and s_rf_sync_sleep and (!rf_busy_s
      && (st_r.rf_state == PLS_PWR_SYNC_WAIT)) |=> !rf_power_on;
   endproperty
   a_sync_release: assert property (p_sync_release) else $error("power kept after pump off");

   property p_async_down;
      @(posedge hclk) disable iff (!hresetn)
      s_rf_steady and (st_r.ctrl.rf_section_sleep && st_r.ctrl.rf_pump_float) |=> !rf_power_on;
   endproperty
   a_async_down: assert property (p_async_down) else $error("asynchronous power-down late");

   property p_auto_wake;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && en_s && rf_wake |=> rf_pump_on && !st_r.ctrl.rf_section_sleep;
   endproperty
   a_auto_wake: assert property (p_auto_wake) else $error("auto-wake ignored");

   property p_wake_float;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && en_s && rf_wake |=> !rf_pump_hiz && !st_r.ctrl.rf_pump_float;
   endproperty
   a_wake_float: assert property (p_wake_float) else $error("auto-wake left pump floated");

   property p_float;
      @(posedge hclk) disable iff (!hresetn)
      s_rf_steady and (!st_r.ctrl.rf_section_sleep && st_r.ctrl.rf_pump_float)
      |=> rf_power_on && rf_pump_hiz && !rf_pump_on;
   endproperty
   a_float: assert property (p_float) else $error("pump not floated");

   property p_sync_pick;
      @(posedge hclk) disable iff (!hresetn)
      (s_rf_steady and s_rf_sync_sleep and !rf_busy_s)
      ##1 clk_en |-> !rf_power_on;
   endproperty
   a_sync_pick: assert property (p_sync_pick) else $error("synchronous power-down stuck");

   property p_both_lock;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && (st_r.ctrl.test_pin_select == PLS_SEL_BOTH_LOCK) && !(rf_lock && if_lock)
      |=> !test_pin;
   endproperty
   a_both_lock: assert property (p_both_lock) else $error("combined lock high while unlocked");

   property p_lock_off;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && !rf_power_on && !if_power_on |=> !rf_lock && !if_lock;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("lock high in power-down");

endmodule : pls_top

// file: dv/pls_loop_model.sv
`timescale 1ns/1ps
module pls_loop_model
   import pls_pkg::*;
(
   // Clock and reset
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   // Levels the bench asks for
   input  wire logic [PLS_ERR_W-1:0] rf_err_lvl,
   input  wire logic [PLS_ERR_W-1:0] if_err_lvl,
   input  wire logic                 busy_lvl,
   // Phase detector and pump side
   output logic                      rf_cmp_strobe,
   output logic                      if_cmp_strobe,
   output logic      [PLS_ERR_W-1:0] rf_phase_err,
   output logic      [PLS_ERR_W-1:0] if_phase_err,
   output logic                      rf_pump_busy,
   output logic                      if_pump_busy
);
   logic [1:0] div_r;
   ////////////////////////////////////////////////////////////////////////////
   // One compare every 4 clocks, 5 MHz, well below where RF lock is unreliable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_r         <= 2'h0;
         rf_cmp_strobe <= 1'b0;
         if_cmp_strobe <= 1'b0;
         rf_phase_err  <= 16'h0000;
         if_phase_err  <= 16'h0000;
      end else begin
         div_r         <= div_r + 2'h1;
         rf_cmp_strobe <= (div_r == 2'h3);
         if_cmp_strobe <= (div_r == 2'h3);
         // Off-strobe error toggles so a design sampling it late is caught
         rf_phase_err  <= (div_r == 2'h3) ? rf_err_lvl : ~rf_phase_err;
         if_phase_err  <= (div_r == 2'h3) ? if_err_lvl : ~if_phase_err;
      end
   end
   assign rf_pump_busy = busy_lvl;
   assign if_pump_busy = busy_lvl;
endmodule : pls_loop_model

// file: dv/pls_top_bench.sv
`timescale 1ns/1ps
module pls_top_bench
   import pls_pkg::*;
;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, chip_enable = 1'b0, busy_lvl = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   // Errors start out of window so no lock forms during the power tests
   logic [15:0] rf_err_lvl = 16'hFFFF, if_err_lvl = 16'hFFFF, rf_pe, if_pe;
   logic clk_en = 1'b1;
   logic hreadyout, hresp, rf_st, if_st, rf_bz, if_bz, rp, rq, rh, ip, iq, ih, test_pin;
   int err_total = 0, cmp_count = 0, tmo = 0, seed = 95;
   pls_loop_model m (.hclk(hclk), .hresetn(hresetn), .rf_err_lvl(rf_err_lvl), .if_err_lvl(if_err_lvl),
      .busy_lvl(busy_lvl), .rf_cmp_strobe(rf_st), .if_cmp_strobe(if_st), .rf_phase_err(rf_pe),
      .if_phase_err(if_pe), .rf_pump_busy(rf_bz), .if_pump_busy(if_bz));
   pls_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .chip_enable(chip_enable), .rf_pump_busy(rf_bz),
      .if_pump_busy(if_bz), .rf_cmp_strobe(rf_st), .rf_phase_err(rf_pe), .if_cmp_strobe(if_st),
      .if_phase_err(if_pe), .rf_power_on(rp), .rf_pump_on(rq), .rf_pump_hiz(rh), .if_power_on(ip),
      .if_pump_on(iq), .if_pump_hiz(ih), .test_pin(test_pin));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #25 hclk = ~hclk;
   end
   // Pin view of a power state: {power_on, pump_on, pump_hiz}
   function automatic logic [2:0] pins(input int st);
      return (st == 0) ? 3'h6 : (st == 1) ? 3'h5 : (st == 2) ? 3'h4 : 3'h0;
   endfunction : pins
   function automatic logic [15:0] good(input int lim);
      return 16'($unsigned($random(seed)) % lim);
   endfunction : good
   task stop_test;
      if (err_total == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask : cyc
   // Lock lands one edge after the strobe rises, pins one edge later
   task strb(input int n);
      repeat (n) @(posedge rf_st);
      cyc(2);
   endtask : strb
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task pwr(input int rs, input int is);
      cyc(4);
      chk("rf pins", pins(rs), {rp, rq, rh});
      chk("if pins", pins(is), {ip, iq, ih});
   endtask : pwr
   always @(posedge hclk) begin
      tmo <= tmo + 1;
      if (tmo == 20000) begin
         err_total++;
         stop_test;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(12);
      hresetn <= 1'b1;
      bus(0, PLS_CTRL_OFS, 0);
      chk("ctrl reset", PLS_CTRL_RST, rd);
      bus(1, 8'h0C, 32'hFFFF_FFFF);
      bus(0, 8'h0C, 0);
      chk("unmapped", 32'h0, rd);
      pwr(3, 3);
      chip_enable <= 1'b1;
      pwr(0, 0);
      bus(1, PLS_CTRL_OFS, 32'h4);
      pwr(1, 0);
      busy_lvl <= 1'b1;
      bus(1, PLS_CTRL_OFS, 32'h1);
      pwr(2, 0);
      bus(0, PLS_STAT_OFS, 0);
      chk("stat rf state", 32'h2, (rd >> PLS_STAT_RF_ST_LSB) & 32'h3);
      busy_lvl <= 1'b0;
      pwr(3, 0);
      bus(1, PLS_CTRL_OFS, 32'hA);
      pwr(0, 3);
      busy_lvl <= 1'b1;
      bus(1, PLS_CTRL_OFS, 32'h5);
      pwr(3, 0);
      bus(1, PLS_CTRL_OFS, 32'h15);
      bus(1, PLS_RFN_OFS, 32'($unsigned($random(seed)) % 32'h40000));
      pwr(0, 0);
      bus(0, PLS_CTRL_OFS, 0);
      chk("wake ctrl", 32'h10, rd);
      bus(1, PLS_CTRL_OFS, 32'h300);
      rf_err_lvl <= good(10000);
      if_err_lvl <= good(15000);
      strb(4);
      rf_err_lvl <= 16'(PLS_RF_ENTER_PS);
      strb(1);
      rf_err_lvl <= good(10000);
      strb(4);
      bus(0, PLS_STAT_OFS, 0);
      chk("lock after break", 32'h2, rd & 32'h3);
      strb(1);
      bus(0, PLS_STAT_OFS, 0);
      chk("lock fifth", 32'h3, rd & 32'h3);
      chk("test pin both", 1'b1, test_pin);
      rf_err_lvl <= PLS_RF_EXIT_PS;
      if_err_lvl <= PLS_IF_EXIT_PS;
      strb(2);
      bus(0, PLS_STAT_OFS, 0);
      chk("lock at exit edge", 32'h3, rd & 32'h3);
      rf_err_lvl <= PLS_RF_EXIT_PS + 16'h1;
      strb(1);
      bus(0, PLS_STAT_OFS, 0);
      chk("rf lost", 32'h2, rd & 32'h3);
      chk("test pin either", 1'b0, test_pin);
      if_err_lvl <= PLS_IF_EXIT_PS + 16'h1;
      rf_err_lvl <= good(10000);
      strb(1);
      bus(0, PLS_STAT_OFS, 0);
      chk("if lost", 32'h0, rd & 32'h3);
      if_err_lvl <= good(15000);
      strb(5);
      bus(0, PLS_STAT_OFS, 0);
      chk("lock both", 32'h7, rd & 32'h7);
      clk_en <= 1'b0;
      chip_enable <= 1'b0;
      cyc(6);
      chk("frozen pins", 32'h6, {rp, rq, rh});
      clk_en <= 1'b1;
      cyc(5);
      bus(0, PLS_STAT_OFS, 0);
      chk("lock in down", 32'h0, rd & 32'h7);
      chk("test pin down", 1'b0, test_pin);
      stop_test;
   end
endmodule : pls_top_bench
